// File: logic/dpss_pkg.sv
// Package for the display power state sequencer
package dpss_pkg;
  // Power states, adjacency ordered
  typedef enum logic [1:0] {
    DPSS_SLEEP   = 2'b00,
    DPSS_STANDBY = 2'b01,
    DPSS_NORMAL  = 2'b10
  } dpss_state_type;

  // Requested-state command codes
  localparam logic [1:0] DPSS_REQ_SLEEP   = 2'h0;
  localparam logic [1:0] DPSS_REQ_STANDBY = 2'h1;
  localparam logic [1:0] DPSS_REQ_NORMAL  = 2'h2;

  // PLL multiplier legal range
  localparam logic [6:0] DPSS_PLL_MULT_MIN = 7'h18;
  localparam logic [6:0] DPSS_PLL_MULT_MAX = 7'h59;

  // PLL settle time and clock rate
  localparam int DPSS_PLL_SETTLE_MS = 10;
  localparam int DPSS_CLK_MHZ       = 200;
  localparam int DPSS_PLL_SETTLE_CYC = DPSS_PLL_SETTLE_MS * 1000 * DPSS_CLK_MHZ;

  // Clock gate enables
  typedef struct packed {
    logic pll_run;
    logic core_logic_clock_en;
    logic memory_side_clock_en;
  } dpss_gate_type;

  localparam dpss_gate_type DPSS_GATE_RESET = '{pll_run: 1'b0,
                                               core_logic_clock_en: 1'b0,
                                               memory_side_clock_en: 1'b0};
endpackage

// File: logic/dpss_settle_timer.sv
// PLL settle timer for the display power state sequencer
`timescale 1ns/10ps
`default_nettype none
module dpss_settle_timer #(
  parameter int SETTLE_CYC = dpss_pkg::DPSS_PLL_SETTLE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy
);
  logic [31:0] count;
  logic [31:0] next_count;

  // Load on start, count down to zero
  always_comb begin
    next_count = count;
    if (abort) begin
      next_count = 32'h0;
    end else if (start) begin
      next_count = 32'(SETTLE_CYC);
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != 32'h0);

  a_settle_load: assert property (@(posedge sys_clk) disable iff (rst)
    (start && !abort) |=> (count == 32'(SETTLE_CYC))) else $error("settle load wrong");
endmodule
`default_nettype wire

// File: logic/dpss_top.sv
// Display power state sequencer top level
`timescale 1ns/10ps
`default_nettype none
module dpss_top #(
  parameter int SETTLE_CYC = dpss_pkg::DPSS_PLL_SETTLE_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   req_valid,
  input  wire logic [1:0]             req_state,
  input  wire logic                   mem_clk_req,
  output logic [1:0]                  power_state,
  output logic                        req_reject,
  output dpss_pkg::dpss_gate_type     gates,
  output logic                        pll_settling,
  output logic                        image_accept,
  output logic                        reg_access_ok
);
  dpss_pkg::dpss_state_type state;
  dpss_pkg::dpss_state_type next_state;
  logic                     reject;
  logic                     next_reject;
  dpss_pkg::dpss_gate_type  gate_q;
  dpss_pkg::dpss_gate_type  next_gate;
  logic                     settle_start;
  logic                     settle_busy;

  // Adjacency test between two states
  function automatic logic is_adjacent(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return (d == 2'h1);
  endfunction

  // State transition, adjacent moves only
  always_comb begin
    next_state   = state;
    next_reject  = 1'b0;
    settle_start = 1'b0;
    if (req_valid) begin
      if ((req_state <= dpss_pkg::DPSS_REQ_NORMAL) && is_adjacent(state, req_state)) begin
        next_state = dpss_pkg::dpss_state_type'(req_state);
        if (state == dpss_pkg::DPSS_SLEEP) begin
          settle_start = 1'b1; // PLL restarts, host must wait
        end
      end else if (req_state != state) begin
        next_reject = 1'b1;
      end
    end
  end

  // Clock gating per state
  always_comb begin
    next_gate = dpss_pkg::DPSS_GATE_RESET;
    case (next_state)
      dpss_pkg::DPSS_SLEEP: begin
        next_gate = dpss_pkg::DPSS_GATE_RESET; // all off incl PLL
      end
      dpss_pkg::DPSS_STANDBY: begin
        next_gate.pll_run = 1'b1; // only PLL runs
      end
      dpss_pkg::DPSS_NORMAL: begin
        next_gate.pll_run              = 1'b1;
        next_gate.core_logic_clock_en  = 1'b1;
        next_gate.memory_side_clock_en = mem_clk_req;
      end
      default: begin
        next_gate = dpss_pkg::DPSS_GATE_RESET;
      end
    endcase
  end

  // State and refusal registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state  <= dpss_pkg::DPSS_SLEEP;
      reject <= 1'b0;
    end else begin
      state  <= next_state;
      reject <= next_reject;
    end
  end

  // Gate registers, glitch-free levels for the clock gates
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_q <= dpss_pkg::DPSS_GATE_RESET;
    end else begin
      gate_q <= next_gate;
    end
  end

  dpss_settle_timer #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_settle (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (settle_start),
    .abort   (next_state == dpss_pkg::DPSS_SLEEP),
    .busy    (settle_busy)
  );

  // Outputs
  assign power_state   = state;
  assign req_reject    = reject;
  assign gates         = gate_q;
  assign pll_settling  = settle_busy;
  assign image_accept  = (state == dpss_pkg::DPSS_NORMAL); // no delay after standby
  assign reg_access_ok = 1'b1; // registers live in every state

  // Gating per state
  a_sleep_gates_off: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_SLEEP) |-> (gate_q == dpss_pkg::DPSS_GATE_RESET))
    else $error("clock on in sleep");
  a_sleep_pll_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_SLEEP) |-> !pll_settling)
    else $error("settle timer runs in sleep");
  a_standby_pll_only: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_STANDBY) |-> (gate_q.pll_run && !gate_q.core_logic_clock_en
      && !gate_q.memory_side_clock_en)) else $error("standby gating wrong");
  a_normal_clocks_on: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_NORMAL) |-> (gate_q.pll_run && gate_q.core_logic_clock_en))
    else $error("normal clocks off");
  a_image_normal_only: assert property (@(posedge sys_clk) disable iff (rst)
    (state != dpss_pkg::DPSS_NORMAL) |-> !image_accept)
    else $error("image taken with core clock off");
  a_memclk_follows_req: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_NORMAL) |-> (gate_q.memory_side_clock_en == $past(mem_clk_req)))
    else $error("memory clock enable wrong");
  a_memclk_normal_only: assert property (@(posedge sys_clk) disable iff (rst)
    gate_q.memory_side_clock_en |-> (state == dpss_pkg::DPSS_NORMAL))
    else $error("memory clock on outside normal");

  // Transition legality
  a_no_skip_jump: assert property (@(posedge sys_clk) disable iff (rst)
    (state != $past(state)) |-> is_adjacent(state, $past(state)))
    else $error("non adjacent move");
  a_skip_rejected: assert property (@(posedge sys_clk) disable iff (rst)
    (req_valid && (state == dpss_pkg::DPSS_SLEEP) && (req_state == dpss_pkg::DPSS_REQ_NORMAL))
    |=> (req_reject && (state == dpss_pkg::DPSS_SLEEP))) else $error("skip not refused");
  a_code3_refused: assert property (@(posedge sys_clk) disable iff (rst)
    (req_valid && (req_state > dpss_pkg::DPSS_REQ_NORMAL)) |=> (req_reject && $stable(state)))
    else $error("unknown code not refused");
  a_reject_keeps_state: assert property (@(posedge sys_clk) disable iff (rst)
    req_reject |-> (state == $past(state)))
    else $error("refused request moved state");
  a_same_state_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (req_valid && (req_state == state)) |=> (!req_reject && $stable(state)))
    else $error("same state request acted on");
  a_state_code_legal: assert property (@(posedge sys_clk) disable iff (rst)
    power_state <= dpss_pkg::DPSS_REQ_NORMAL)
    else $error("unknown state code");

  // Helper count of cycles with the PLL settle flag high
  logic [31:0] settle_seen;
  logic [31:0] next_settle_seen;

  always_comb begin
    next_settle_seen = 32'h0;
    if (pll_settling) begin
      next_settle_seen = settle_seen + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      settle_seen <= 32'h0;
    end else begin
      settle_seen <= next_settle_seen;
    end
  end

  // PLL settle window after leaving sleep; a sleep request may cut it short
  a_settle_after_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (($past(state) == dpss_pkg::DPSS_SLEEP) && (state == dpss_pkg::DPSS_STANDBY))
    |=> (pll_settling || (state == dpss_pkg::DPSS_SLEEP))) else $error("no settle after wake");
  a_settle_only_wake: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(pll_settling) |-> (($past(state) == dpss_pkg::DPSS_SLEEP)
      && (state == dpss_pkg::DPSS_STANDBY))) else $error("settle without wake");
  a_settle_length: assert property (@(posedge sys_clk) disable iff (rst)
    ($fell(pll_settling) && (state != dpss_pkg::DPSS_SLEEP))
    |-> (settle_seen == 32'(SETTLE_CYC))) else $error("settle length wrong");

  // Standby exit needs no wait before image data
  a_standby_exit_fast: assert property (@(posedge sys_clk) disable iff (rst)
    (req_valid && (state == dpss_pkg::DPSS_STANDBY) && (req_state == dpss_pkg::DPSS_REQ_NORMAL))
    |=> image_accept) else $error("image not accepted");

  // Register access in low-power states
  a_regs_in_sleep: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_SLEEP) |-> reg_access_ok) else $error("regs blocked");
  a_regs_in_standby: assert property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_STANDBY) |-> reg_access_ok) else $error("regs blocked");

  // Main scenarios
  c_wake_up: cover property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_SLEEP) ##1 (state == dpss_pkg::DPSS_STANDBY)
    ##[1:20] (state == dpss_pkg::DPSS_NORMAL));
  c_go_sleep: cover property (@(posedge sys_clk) disable iff (rst)
    (state == dpss_pkg::DPSS_STANDBY) ##1 (state == dpss_pkg::DPSS_SLEEP));
  c_reject: cover property (@(posedge sys_clk) disable iff (rst) req_reject);
  c_settle_done: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(pll_settling) && (state == dpss_pkg::DPSS_STANDBY));
  c_settle_abort: cover property (@(posedge sys_clk) disable iff (rst)
    $fell(pll_settling) && (state == dpss_pkg::DPSS_SLEEP));
endmodule
`default_nettype wire

// File: tb/dpss_host_model.sv
// Host model that sends power state requests to the sequencer
`timescale 1ns/10ps
`default_nettype none
module dpss_host_model (
  input  wire logic  sys_clk,
  output logic       req_valid,
  output logic [1:0] req_state,
  output logic       mem_clk_req
);
  // Idle host at time zero
  initial begin
    req_valid   = 1'b0;
    req_state   = 2'h0;
    mem_clk_req = 1'b0;
  end
  // One-cycle request; code inverted once released
  // Host keeps image memory untouched in sleep
  // Bring-up walks sleep, standby, normal in order
  // Display setup and image writes stay outside this model
  // PLL multiplier kept within its legal span by the host
  // Memory power commands only once the controller idles
  // Panel output and blending stopped before idling memory
  // Memory power-save precedes dropping mem_clk_req
  task automatic issue(input logic [1:0] st, input logic mem);
    @(negedge sys_clk);
    req_valid   = 1'b1;
    req_state   = st;
    mem_clk_req = mem;
    @(negedge sys_clk);
    req_valid = 1'b0;
    req_state = ~st;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the power state sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int SETTLE = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid, mem_clk_req, req_reject, pll_settling, image_accept, reg_access_ok;
  logic [1:0] req_state, power_state;
  dpss_pkg::dpss_gate_type gates;
  int failures = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  dpss_host_model i_host (.sys_clk(sys_clk), .req_valid(req_valid), .req_state(req_state),
    .mem_clk_req(mem_clk_req));
  dpss_top #(.SETTLE_CYC(SETTLE)) i_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_state(req_state), .mem_clk_req(mem_clk_req), .power_state(power_state),
    .req_reject(req_reject), .gates(gates), .pll_settling(pll_settling),
    .image_accept(image_accept), .reg_access_ok(reg_access_ok));
  // Compare one value
  task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // State after reset: sleep, all clocks off
  task automatic t_reset();
    check("state", {1'b0, power_state}, 3'h0);
    check("gates", gates, 3'h0);
    check("settle", {2'b0, pll_settling}, 3'h0);
    check("regs", {2'b0, reg_access_ok}, 3'h1);
  endtask
  // Non-adjacent and unknown codes refused from sleep
  task automatic t_refuse();
    i_host.issue(dpss_pkg::DPSS_REQ_SLEEP, 1'b0);
    check("same", {2'b0, req_reject}, 3'h0);
    check("same_state", {1'b0, power_state}, 3'h0);
    i_host.issue(dpss_pkg::DPSS_REQ_NORMAL, 1'b1);
    check("reject", {2'b0, req_reject}, 3'h1);
    check("state", {1'b0, power_state}, 3'h0);
    i_host.issue(2'h3, 1'b0);
    check("reject3", {2'b0, req_reject}, 3'h1);
    check("gates", gates, 3'h0);
  endtask
  // Wake to standby and time the PLL settle
  task automatic t_wake();
    int n;
    i_host.issue(dpss_pkg::DPSS_REQ_STANDBY, 1'b1);
    check("state", {1'b0, power_state}, 3'h1);
    check("gates", gates, 3'h4);
    check("regs", {2'b0, reg_access_ok}, 3'h1);
    n = 0;
    while (pll_settling === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    check("settle", n[2:0], SETTLE[2:0]);
    check("settle_hi", n[5:3], SETTLE[5:3]);
  endtask
  // Normal run, refused jump, then step back to sleep
  task automatic t_run();
    i_host.issue(dpss_pkg::DPSS_REQ_NORMAL, 1'b1);
    check("state", {1'b0, power_state}, 3'h2);
    check("image", {2'b0, image_accept}, 3'h1);
    check("gates", gates, 3'h7);
    i_host.issue(dpss_pkg::DPSS_REQ_SLEEP, 1'b0);
    check("reject", {2'b0, req_reject}, 3'h1);
    check("state", {1'b0, power_state}, 3'h2);
    check("gates_mem", gates, 3'h6);
    i_host.issue(dpss_pkg::DPSS_REQ_STANDBY, 1'b0);
    check("gates", gates, 3'h4);
    check("image", {2'b0, image_accept}, 3'h0);
    i_host.issue(dpss_pkg::DPSS_REQ_SLEEP, 1'b0);
    check("gates", gates, 3'h0);
    check("regs", {2'b0, reg_access_ok}, 3'h1);
  endtask
  // Sleep request while the PLL settles cuts the wait short
  task automatic t_abort();
    i_host.issue(dpss_pkg::DPSS_REQ_STANDBY, 1'b1);
    i_host.issue(dpss_pkg::DPSS_REQ_SLEEP, 1'b0);
    check("abort_state", {1'b0, power_state}, 3'h0);
    check("abort_settle", {2'b0, pll_settling}, 3'h0);
    check("abort_gates", gates, 3'h0);
  endtask
  // Reset in mid-run while settling: back to sleep, timer cleared
  task automatic t_midreset();
    i_host.issue(dpss_pkg::DPSS_REQ_STANDBY, 1'b1);
    check("settle_on", {2'b0, pll_settling}, 3'h1);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check("rst_state", {1'b0, power_state}, 3'h0);
    check("rst_gates", gates, 3'h0);
    check("rst_settle", {2'b0, pll_settling}, 3'h0);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_refuse();
    t_wake();
    t_run();
    t_abort();
    t_midreset();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #(5 * 2000);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
